// >>> design/sdecc_addr_queue.v
`timescale 1ns/1ps
`default_nettype none
`include "sdecc_defines.vh"

// two-entry queue of burst addresses for single-bit errors
module sdecc_addr_queue #(
    parameter AW = 32
) (
    // clock and reset
    input  wire          hclk,
    input  wire          hresetn,
    input  wire          clk_en,
    // push side
    input  wire          push,
    input  wire [AW-1:0] push_addr,
    // pop side
    input  wire          pop_one,
    input  wire          pop_two,
    // state
    output wire [AW-1:0] head_addr,
    output wire [1:0]    level
);

    reg [AW-1:0] entry_r [0:1];
    reg [1:0]    level_r;
    reg [1:0]    level_nxt;
    reg [AW-1:0] e0_nxt;
    reg [AW-1:0] e1_nxt;
    reg [1:0]    lvl_tmp;

    // pops apply first, then the push lands in the freed slot
    always @* begin
        e0_nxt  = entry_r[0];
        e1_nxt  = entry_r[1];
        lvl_tmp = level_r;
        if (pop_two) begin
            lvl_tmp = 2'd0;
            e0_nxt  = {AW{1'b0}};
            e1_nxt  = {AW{1'b0}};
        end else if (pop_one && level_r != 2'd0) begin
            lvl_tmp = level_r - 2'd1;
            e0_nxt  = entry_r[1];
            e1_nxt  = {AW{1'b0}};
        end
        level_nxt = lvl_tmp;
        // a full queue keeps its entries until software pops
        if (push && lvl_tmp != 2'd2) begin
            if (lvl_tmp == 2'd0)
                e0_nxt = push_addr;
            else
                e1_nxt = push_addr;
            level_nxt = lvl_tmp + 2'd1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            entry_r[0] <= {AW{1'b0}};
            entry_r[1] <= {AW{1'b0}};
            level_r    <= 2'd0;
        end else if (clk_en) begin
            entry_r[0] <= e0_nxt;
            entry_r[1] <= e1_nxt;
            level_r    <= level_nxt;
        end
    end

    assign head_addr = entry_r[0];
    assign level     = level_r;

endmodule
`default_nettype wire

// >>> design/sdecc_defines.vh
`ifndef SDECC_DEFINES_VH
`define SDECC_DEFINES_VH

// register byte offsets
`define SDECC_OFF_MAP_LOW      12'h000
`define SDECC_OFF_ADDR_QUEUE   12'h004
`define SDECC_OFF_DOUBLE_LOG   12'h008
`define SDECC_OFF_MAP_HIGH     12'h00c
`define SDECC_OFF_IRQ_STATUS   12'h010
`define SDECC_OFF_IRQ_ENABLE   12'h014
`define SDECC_OFF_IRQ_CLEAR    12'h018
`define SDECC_OFF_QUEUE_LEVEL  12'h01c

// reset values
`define SDECC_RST_WORD         32'h00000000

// pop / clear command values
`define SDECC_CMD_POP_ONE      32'h00000001
`define SDECC_CMD_POP_TWO      32'h00000002
`define SDECC_CMD_CLR_DOUBLE   32'h00000001

// interrupt status bit positions
`define SDECC_IRQ_SINGLE       0
`define SDECC_IRQ_DOUBLE       1
`define SDECC_IRQ_QUEUE_FULL   2
`define SDECC_IRQ_BITS         3

// queue depth
`define SDECC_QUEUE_DEPTH      2

`endif

// >>> design/sdecc_error_log.v
`timescale 1ns/1ps
`default_nettype none
`include "sdecc_defines.vh"

module sdecc_error_log #(
    parameter DW = 64,
    parameter AW = 32
) (
    // clock, reset, enable
    input  wire          hclk,
    input  wire          hresetn,
    input  wire          clk_en,
    // ahb-lite slave
    input  wire          hsel,
    input  wire [11:0]   haddr,
    input  wire [1:0]    htrans,
    input  wire          hwrite,
    input  wire [2:0]    hsize,
    input  wire          hready,
    input  wire [31:0]   hwdata,
    output wire [31:0]   hrdata,
    output wire          hreadyout,
    output wire          hresp,
    // ecc checker events, same clock
    input  wire          single_err,
    input  wire [DW-1:0] single_err_bits,
    input  wire          double_err,
    input  wire [AW-1:0] burst_addr,
    // interrupt
    output wire          irq
);

    localparam NB = `SDECC_IRQ_BITS;

    // offsets held at 12 bits so the word index can be sliced off
    localparam [11:0] OFF_MAP_LOW  = `SDECC_OFF_MAP_LOW;
    localparam [11:0] OFF_QUEUE    = `SDECC_OFF_ADDR_QUEUE;
    localparam [11:0] OFF_DOUBLE   = `SDECC_OFF_DOUBLE_LOG;
    localparam [11:0] OFF_MAP_HIGH = `SDECC_OFF_MAP_HIGH;
    localparam [11:0] OFF_STATUS   = `SDECC_OFF_IRQ_STATUS;
    localparam [11:0] OFF_ENABLE   = `SDECC_OFF_IRQ_ENABLE;
    localparam [11:0] OFF_CLEAR    = `SDECC_OFF_IRQ_CLEAR;
    localparam [11:0] OFF_LEVEL    = `SDECC_OFF_QUEUE_LEVEL;

    localparam [9:0]  IX_MAP_LOW   = OFF_MAP_LOW[11:2];
    localparam [9:0]  IX_QUEUE     = OFF_QUEUE[11:2];
    localparam [9:0]  IX_DOUBLE    = OFF_DOUBLE[11:2];
    localparam [9:0]  IX_MAP_HIGH  = OFF_MAP_HIGH[11:2];
    localparam [9:0]  IX_STATUS    = OFF_STATUS[11:2];
    localparam [9:0]  IX_ENABLE    = OFF_ENABLE[11:2];
    localparam [9:0]  IX_CLEAR     = OFF_CLEAR[11:2];
    localparam [9:0]  IX_LEVEL     = OFF_LEVEL[11:2];

    // bus address phase capture
    reg          wr_pend_r;
    reg [11:0]   addr_r;
    reg [31:0]   rdata_r;
    reg [31:0]   rdata_nxt;

    // register state
    reg [31:0]   map_low_r;
    reg [31:0]   map_high_r;
    reg [AW-1:0] dbl_log_r;
    reg          dbl_full_r;
    reg [NB-1:0] irq_stat_r;
    reg [NB-1:0] irq_en_r;

    // next values
    wire [31:0]   map_low_nxt;
    wire [31:0]   map_high_nxt;
    reg  [AW-1:0] dbl_log_nxt;
    reg           dbl_full_nxt;
    wire [NB-1:0] irq_stat_nxt;
    reg  [NB-1:0] irq_en_nxt;

    // per-bit set and clear requests
    wire [31:0]   set_low;
    wire [31:0]   set_high;
    wire [31:0]   clr_low;
    wire [31:0]   clr_high;
    wire [NB-1:0] irq_set;
    wire [NB-1:0] irq_clr;

    // queue side
    wire [AW-1:0] q_head;
    wire [1:0]    q_level;
    wire          q_push;
    wire          q_full_evt;

    // one word decoder shared by the read and write paths
    function hit;
        input [11:0] a;
        input [9:0]  ix;
        begin
            hit = (a[11:2] == ix);
        end
    endfunction

    // address phase qualifiers
    wire addr_ok = hsel && hready && htrans[1];
    wire rd_ok   = addr_ok && !hwrite;
    wire wr_ok   = addr_ok && hwrite;

    // read selects decode the live address
    wire rd_low  = rd_ok && hit(haddr, IX_MAP_LOW);
    wire rd_q    = rd_ok && hit(haddr, IX_QUEUE);
    wire rd_dbl  = rd_ok && hit(haddr, IX_DOUBLE);
    wire rd_high = rd_ok && hit(haddr, IX_MAP_HIGH);
    wire rd_stat = rd_ok && hit(haddr, IX_STATUS);
    wire rd_ien  = rd_ok && hit(haddr, IX_ENABLE);
    wire rd_lvl  = rd_ok && hit(haddr, IX_LEVEL);

    // write strobes decode the held address in the data phase
    wire wr_low  = wr_pend_r && hit(addr_r, IX_MAP_LOW);
    wire wr_q    = wr_pend_r && hit(addr_r, IX_QUEUE);
    wire wr_dbl  = wr_pend_r && hit(addr_r, IX_DOUBLE);
    wire wr_high = wr_pend_r && hit(addr_r, IX_MAP_HIGH);
    wire wr_en   = wr_pend_r && hit(addr_r, IX_ENABLE);
    wire wr_clr  = wr_pend_r && hit(addr_r, IX_CLEAR);

    // command values carried in the data phase
    wire pop_one = wr_q && (hwdata == `SDECC_CMD_POP_ONE);
    wire pop_two = wr_q && (hwdata == `SDECC_CMD_POP_TWO);
    wire dbl_clr = wr_dbl && (hwdata == `SDECC_CMD_CLR_DOUBLE);

    // a push that lands in the last free slot fills the queue
    assign q_push     = single_err;
    assign q_full_evt = q_push && (q_level == 2'd1) && !pop_one
                        && !pop_two;

    sdecc_addr_queue #(
        .AW (AW)
    ) sdecc_addr_queue_i (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_en    (clk_en),
        .push      (q_push),
        .push_addr (burst_addr),
        .pop_one   (pop_one),
        .pop_two   (pop_two),
        .head_addr (q_head),
        .level     (q_level)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 12'h000;
        end else if (clk_en) begin
            wr_pend_r <= wr_ok;
            if (addr_ok)
                addr_r <= haddr;
        end
    end

    // single error events set map bits; software ones clear them
    assign set_low  = {32{single_err}} & single_err_bits[31:0];
    assign set_high = {32{single_err}} & single_err_bits[63:32];
    assign clr_low  = wr_low ? hwdata : 32'h00000000;
    assign clr_high = wr_high ? hwdata : 32'h00000000;

    genvar gi;

    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_map
            // a set in the same cycle as its clear wins
            assign map_low_nxt[gi]  = set_low[gi] |
                                      (map_low_r[gi] & ~clr_low[gi]);
            assign map_high_nxt[gi] = set_high[gi] |
                                      (map_high_r[gi] & ~clr_high[gi]);
        end
    endgenerate

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            map_low_r  <= `SDECC_RST_WORD;
            map_high_r <= `SDECC_RST_WORD;
        end else if (clk_en) begin
            map_low_r  <= map_low_nxt;
            map_high_r <= map_high_nxt;
        end
    end

    // only the first double error is kept until software clears it
    always @* begin
        dbl_log_nxt  = dbl_log_r;
        dbl_full_nxt = dbl_full_r;
        if (dbl_clr) begin
            dbl_log_nxt  = {AW{1'b0}};
            dbl_full_nxt = 1'b0;
        end
        // a flag, not the value, marks the log taken, so address 0 counts
        if (double_err && !dbl_full_nxt) begin
            dbl_log_nxt  = burst_addr;
            dbl_full_nxt = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbl_log_r  <= {AW{1'b0}};
            dbl_full_r <= 1'b0;
        end else if (clk_en) begin
            dbl_log_r  <= dbl_log_nxt;
            dbl_full_r <= dbl_full_nxt;
        end
    end

    // status bits are sticky; a new event beats a clear in the same cycle
    assign irq_set[`SDECC_IRQ_SINGLE]     = single_err;
    assign irq_set[`SDECC_IRQ_DOUBLE]     = double_err;
    assign irq_set[`SDECC_IRQ_QUEUE_FULL] = q_full_evt;
    assign irq_clr = wr_clr ? hwdata[NB-1:0] : {NB{1'b0}};

    generate
        for (gi = 0; gi < NB; gi = gi + 1) begin : g_irq
            assign irq_stat_nxt[gi] = irq_set[gi] |
                                      (irq_stat_r[gi] & ~irq_clr[gi]);
        end
    endgenerate

    always @* begin
        irq_en_nxt = irq_en_r;
        if (wr_en)
            irq_en_nxt = hwdata[NB-1:0];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= {NB{1'b0}};
            irq_en_r   <= {NB{1'b0}};
        end else if (clk_en) begin
            irq_stat_r <= irq_stat_nxt;
            irq_en_r   <= irq_en_nxt;
        end
    end

    // read data is taken in the address phase and stands in the data phase
    always @* begin
        rdata_nxt = 32'h00000000;
        if (rd_low)
            rdata_nxt = map_low_r;
        if (rd_q)
            rdata_nxt = q_head;
        if (rd_dbl)
            rdata_nxt = dbl_log_r;
        if (rd_high)
            rdata_nxt = map_high_r;
        if (rd_stat)
            rdata_nxt = {{(32-NB){1'b0}}, irq_stat_r};
        if (rd_ien)
            rdata_nxt = {{(32-NB){1'b0}}, irq_en_r};
        if (rd_lvl)
            rdata_nxt = {30'h0, q_level};
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            rdata_r <= 32'h00000000;
        else if (clk_en && rd_ok)
            rdata_r <= rdata_nxt;
    end

    assign hrdata    = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(irq_stat_r & irq_en_r);

endmodule
`default_nettype wire

// >>> tb/sdecc_error_log_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sdecc_error_log_bench;
    logic        hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout;
    logic        hresp, single_err, double_err, irq;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, q, burst_addr;
    logic [63:0] single_err_bits;
    int          mismatches, checks_done;
    assign hready = hreadyout;
    sdecc_error_log sdecc_error_log_i (.hclk, .hresetn, .clk_en, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
        .hreadyout, .hresp, .single_err, .single_err_bits, .double_err,
        .burst_addr, .irq);
    task chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, e);
    endtask
    // lowering takes its own cycle so back-to-back events never collide
    task ev(input logic s, input logic [63:0] b, input logic d,
            input logic [31:0] a);
        single_err <= s; single_err_bits <= b; double_err <= d;
        burst_addr <= a;
        @(posedge hclk);
        single_err <= 1'b0; double_err <= 1'b0;
        @(posedge hclk);
    endtask
    task t_reset;
        for (int i = 0; i < 9; i++) rd(12'(i * 4), 32'h0);
    endtask
    task t_map;
        ev(1, 64'h0000_0000_8000_0000, 0, 32'h10);
        ev(1, 64'h8000_0000_0000_0000, 0, 32'h11);
        ev(1, 64'h0000_0001_0000_0000, 0, 32'h12);
        rd(12'h00c, 32'h80000001);
        clk_en <= 1'b0;
        ev(1, 64'h2, 0, 32'h13);
        clk_en <= 1'b1;
        ev(1, 64'h1, 0, 32'h14);
        rd(12'h000, 32'h80000001);
        xfer(1, 12'h000, 32'h1);
        rd(12'h000, 32'h80000000);
        xfer(1, 12'h000, 32'h0);
        rd(12'h000, 32'h80000000);
        xfer(1, 12'h000, 32'hffffffff);
        rd(12'h000, 32'h0);
        xfer(1, 12'h00c, 32'hffffffff);
        rd(12'h00c, 32'h0);
    endtask
    task t_queue;
        xfer(1, 12'h004, 32'h2);
        rd(12'h01c, 32'h0);
        ev(1, 64'h4, 0, 32'ha1);
        ev(1, 64'h4, 0, 32'ha2);
        ev(1, 64'h4, 0, 32'ha3);
        rd(12'h01c, 32'h2);
        xfer(1, 12'h004, 32'h3);
        rd(12'h004, 32'ha1);
        xfer(1, 12'h004, 32'h1);
        rd(12'h004, 32'ha2);
        xfer(1, 12'h004, 32'h1);
        rd(12'h004, 32'h0);
        ev(1, 64'h4, 0, 32'ha4);
        ev(1, 64'h4, 0, 32'ha5);
        xfer(1, 12'h004, 32'h2);
        rd(12'h01c, 32'h0);
    endtask
    task t_double;
        ev(0, 64'h0, 1, 32'hd1);
        ev(0, 64'h0, 1, 32'hd2);
        rd(12'h008, 32'hd1);
        xfer(1, 12'h008, 32'h2);
        rd(12'h008, 32'hd1);
        xfer(1, 12'h008, 32'h1);
        rd(12'h008, 32'h0);
        ev(0, 64'h0, 1, 32'hd3);
        rd(12'h008, 32'hd3);
    endtask
    task t_irq;
        rd(12'h010, 32'h7);
        chk("irq masked", {31'h0, irq}, 32'h0);
        xfer(1, 12'h014, 32'h7);
        #1 chk("irq on", {31'h0, irq}, 32'h1);
        xfer(1, 12'h018, 32'h7);
        rd(12'h010, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        xfer(1, 12'h014, 32'h2);
        ev(1, 64'h1, 0, 32'h0);
        chk("irq disabled", {31'h0, irq}, 32'h0);
        rd(12'h010, 32'h1);
        ev(0, 64'h0, 1, 32'h0);
        chk("irq double", {31'h0, irq}, 32'h1);
    endtask
    // a reset in mid-run must drop every log, including the taken flag
    task t_rerun;
        ev(1, 64'h1, 1, 32'h5);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(12'h000, 32'h0);
        rd(12'h008, 32'h0);
        rd(12'h01c, 32'h0);
        rd(12'h010, 32'h0);
        chk("irq after reset", {31'h0, irq}, 32'h0);
        ev(0, 64'h0, 1, 32'h6);
        rd(12'h008, 32'h6);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        hclk = 0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        repeat (2000) @(posedge hclk);
        mismatches++;
        test_done;
    end
    initial begin
        hresetn = 0; clk_en = 1; hsel = 0; haddr = 0; htrans = 0;
        hwrite = 0; hsize = 3'b010; hwdata = 0; single_err = 0;
        single_err_bits = 0; double_err = 0; burst_addr = 0;
        mismatches = 0; checks_done = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_map;
        t_queue;
        t_double;
        t_irq;
        t_rerun;
        test_done;
    end
endmodule
`default_nettype wire

// >>> tb/sdecc_error_log_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sdecc_error_log_checker #(
    parameter DW = 64,
    parameter AW = 32
) (
    // clock and enable
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          clk_en,
    // ahb-lite
    input wire logic          hsel,
    input wire logic [11:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [2:0]    hsize,
    input wire logic          hready,
    input wire logic [31:0]   hwdata,
    input wire logic [31:0]   hrdata,
    input wire logic          hreadyout,
    input wire logic          hresp,
    // events and interrupt
    input wire logic          single_err,
    input wire logic [DW-1:0] single_err_bits,
    input wire logic          double_err,
    input wire logic [AW-1:0] burst_addr,
    input wire logic          irq
);
    logic rd;
    logic wr;
    assign rd = hsel & hready & htrans[1] & clk_en & ~hwrite;
    assign wr = hsel & hready & htrans[1] & clk_en & hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_LOW_SET: assert property (
        single_err && clk_en && single_err_bits[0] ##2 rd && haddr == 12'h000
        |=> hrdata[0]) else $error("low map bit missed");
    AST_HIGH_SET: assert property (
        single_err && clk_en && single_err_bits[32] ##2 rd && haddr == 12'h00c
        |=> hrdata[0]) else $error("high map bit missed");
    AST_W1C: assert property (
        wr && haddr == 12'h000 ##1 hwdata == 32'hffffffff && clk_en &&
        !single_err ##1 rd && haddr == 12'h000 |=> hrdata == 32'h0)
        else $error("map not cleared");
    AST_DBL_CLR: assert property (
        wr && haddr == 12'h008 ##1 hwdata == 32'h1 && clk_en && !double_err
        ##1 rd && haddr == 12'h008 |=> hrdata == 32'h0)
        else $error("double log not cleared");
    AST_LEVEL: assert property (
        rd && haddr == 12'h01c |=> hrdata <= 32'h2) else $error("bad level");
    AST_UNMAP: assert property (
        rd && haddr >= 12'h020 |=> hrdata == 32'h0) else $error("unmapped");
    AST_HOLD: assert property (
        !rd |=> $stable(hrdata)) else $error("read data moved");
    AST_OKAY: assert property (
        hreadyout && !hresp) else $error("not ready or error response");
endmodule
bind sdecc_error_log sdecc_error_log_checker #(.DW(DW), .AW(AW)) chk_i (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .single_err,
    .single_err_bits, .double_err, .burst_addr, .irq);
`default_nettype wire
